// ==== hdl/pwr_seq_regs.svh ====
// Register offsets, field positions, reset values and timing counts of the power sequencer.
`ifndef PWR_SEQ_REGS_SVH
`define PWR_SEQ_REGS_SVH
`define IDX_SEQ_STATUS 8'h20
`define IDX_STATE_REQUEST 8'h22
`define IDX_STATE_MONITOR 8'h23
`define IDX_SETTLE_HIGH 8'h24
`define IDX_SETTLE_LOW 8'h25
`define REQ_SLEEP_BIT 7
`define REQ_ALL_HOST_BIT 1
`define MON_OWNER_BIT 7
`define SETTLE_RESET 16'h0000
`define CLK_PERIOD_NS 10
`define PLL_SETTLE_NS 250000
`define PLL_SETTLE_CYC (`PLL_SETTLE_NS / `CLK_PERIOD_NS)
`endif

// ==== hdl/pwr_seq_pkg.sv ====
// Types shared by the power sequencer and its bench.
package pwr_seq_pkg;
  typedef enum logic [1:0] {ST_IDLE, ST_BUSY, ST_OSC_WAIT, ST_PLL_WAIT} seq_state_e;
  typedef struct packed {
    logic [7:0] address;
    logic read;
    logic write;
    logic [31:0] writedata;
    logic [3:0] byteenable;
  } avmm_req_s;
  typedef struct packed {
    logic [31:0] readdata;
    logic waitrequest;
  } avmm_rsp_s;
  typedef struct packed {
    logic osc_enable;
    logic gated_osc_clock_en;
    logic base_pll_en;
    logic device_hs_pll_en;
    logic host_hs_pll_en;
    logic transfer_owner_flag;
    logic device_xfer_en;
    logic host_xfer_en;
  } clk_ctrl_s;
endpackage

// ==== hdl/power_state_clock_sequencer.sv ====
// Power state sequencer: oscillator, base PLL and two high-speed PLLs behind an Avalon-MM slave.
// Behaviour
// - Sleep to all-active: osc, settle, base, hs.
// - Snooze to all-active: base, wait, hs, wait.
// - Base-active to all-active: both hs, wait.
// - Device-active to all-active: host hs, wait.
// - Substate swap only rewrites owner flag.
// - Clear request bit on completion, set done only if a state changed.
// - All-active: only owner function transfers data.
// - Owner flag bit 7: 0 device, 1 host.
// - State code mirrors oscillator and PLL status.
// - Requests from sleep start the oscillator.
// - Settle count down, then open clock gate.
// - Registers stay accessible in sleep, snooze.
// - Mask synchronous interrupts while in snooze.
// - All-active to device-active stops host hs.
`timescale 1ns/1ps
`include "pwr_seq_regs.svh"
module power_state_clock_sequencer #(
  parameter logic [15:0] PLL_SETTLE_CYC = 16'(`PLL_SETTLE_CYC)
) (
  // Clock and reset.
  input wire logic clock_i,
  input wire logic rst_b_i,
  // Register bus.
  input wire pwr_seq_pkg::avmm_req_s avmm_i,
  output pwr_seq_pkg::avmm_rsp_s avmm_o,
  // Interrupt sources from the controller.
  input wire logic sync_irq_i,
  input wire logic async_irq_i,
  // Oscillator and PLL controls.
  output pwr_seq_pkg::clk_ctrl_s clk_ctrl_o,
  output logic interrupt_out_n_o
);
  import pwr_seq_pkg::*;

  typedef struct packed {
    seq_state_e st;
    logic [6:0] req;
    logic [6:0] act;
    logic moved;
    logic done;
    logic [15:0] cnt;
    logic [15:0] settle;
    clk_ctrl_s ctl;
    logic irq_n;
    logic wait_n;
    logic [7:0] rdata;
  } seq_s;

  seq_s s_ff;
  seq_s nxt_s_ff;
  logic [4:0] tgt;
  logic [3:0] state_code;
  logic access;
  logic fin;

  // Target of the active request: osc, base, device hs, host hs, owner.
  always_comb begin
    tgt = 5'h00;
    unique case (1'b1)
      s_ff.act[6]: tgt = 5'h00;
      s_ff.act[5]: tgt = 5'h10;
      s_ff.act[4]: tgt = 5'h18;
      s_ff.act[3]: tgt = 5'h1C;
      s_ff.act[2]: tgt = 5'h1A;
      s_ff.act[1]: tgt = 5'h1E;
      s_ff.act[0]: tgt = 5'h1F;
      default: tgt = 5'h00;
    endcase
  end

  // Code bit 0 follows the opened clock gate, so it reads on only once the oscillator settled.
  assign state_code = {s_ff.ctl.host_hs_pll_en, s_ff.ctl.device_hs_pll_en,
                       s_ff.ctl.base_pll_en, s_ff.ctl.gated_osc_clock_en};
  assign access = avmm_i.read | avmm_i.write;
  // The target keeps the oscillator in its top bit while the code keeps the gate in its bottom bit.
  assign fin = (s_ff.st == ST_BUSY) && (state_code == {tgt[1], tgt[2], tgt[3], tgt[4]});

  always_comb begin
    nxt_s_ff = s_ff;
    // Every access gets exactly one wait state, and a write lands on the edge after it, which ends the access.
    nxt_s_ff.wait_n = access & s_ff.wait_n ? 1'b0 : 1'b1;
    if (avmm_i.write && !s_ff.wait_n && avmm_i.byteenable[0]) begin
      unique case ({2'b00, avmm_i.address[7:2]})
        `IDX_SEQ_STATUS: nxt_s_ff.done = s_ff.done & ~avmm_i.writedata[0];
        `IDX_STATE_REQUEST: nxt_s_ff.req = avmm_i.writedata[7:1];
        `IDX_SETTLE_HIGH: nxt_s_ff.settle[15:8] = avmm_i.writedata[7:0];
        `IDX_SETTLE_LOW: nxt_s_ff.settle[7:0] = avmm_i.writedata[7:0];
        default: nxt_s_ff.settle = s_ff.settle;
      endcase
    end
    if (avmm_i.read && s_ff.wait_n) begin
      unique case ({2'b00, avmm_i.address[7:2]})
        `IDX_SEQ_STATUS: nxt_s_ff.rdata = {7'h00, s_ff.done};
        `IDX_STATE_REQUEST: nxt_s_ff.rdata = {s_ff.req, 1'b0};
        `IDX_STATE_MONITOR: nxt_s_ff.rdata = {s_ff.ctl.transfer_owner_flag, 3'h0, state_code};
        `IDX_SETTLE_HIGH: nxt_s_ff.rdata = s_ff.settle[15:8];
        `IDX_SETTLE_LOW: nxt_s_ff.rdata = s_ff.settle[7:0];
        default: nxt_s_ff.rdata = 8'h00;
      endcase
    end
    unique case (s_ff.st)
      ST_IDLE: begin
        // One request is latched at a time; later bits wait in the register.
        for (int i = 0; i < 7; i++) begin
          if (s_ff.req[i] && nxt_s_ff.st == ST_IDLE) begin
            nxt_s_ff.act = 7'(1 << i);
            nxt_s_ff.moved = 1'b0;
            nxt_s_ff.st = ST_BUSY;
          end
        end
      end
      ST_BUSY: begin
        // Stop first, in the order device hs, host hs, base, oscillator; then start upward.
        if (s_ff.ctl.device_hs_pll_en && !tgt[2]) begin
          nxt_s_ff.ctl.device_hs_pll_en = 1'b0;
          nxt_s_ff.moved = 1'b1;
        end else if (s_ff.ctl.host_hs_pll_en && !tgt[1]) begin
          nxt_s_ff.ctl.host_hs_pll_en = 1'b0;
          nxt_s_ff.moved = 1'b1;
        end else if (s_ff.ctl.base_pll_en && !tgt[3]) begin
          nxt_s_ff.ctl.base_pll_en = 1'b0;
          nxt_s_ff.moved = 1'b1;
        end else if (s_ff.ctl.osc_enable && !tgt[4]) begin
          nxt_s_ff.ctl.osc_enable = 1'b0;
          nxt_s_ff.ctl.gated_osc_clock_en = 1'b0;
          nxt_s_ff.moved = 1'b1;
        end else if (!s_ff.ctl.osc_enable && tgt[4]) begin
          nxt_s_ff.ctl.osc_enable = 1'b1;
          nxt_s_ff.cnt = s_ff.settle;
          nxt_s_ff.moved = 1'b1;
          nxt_s_ff.st = ST_OSC_WAIT;
        end else if (!s_ff.ctl.base_pll_en && tgt[3]) begin
          nxt_s_ff.ctl.base_pll_en = 1'b1;
          nxt_s_ff.cnt = PLL_SETTLE_CYC - 16'h0001;
          nxt_s_ff.moved = 1'b1;
          nxt_s_ff.st = ST_PLL_WAIT;
        end else if ((!s_ff.ctl.device_hs_pll_en && tgt[2]) || (!s_ff.ctl.host_hs_pll_en && tgt[1])) begin
          // Whichever hs PLLs the target needs start together and share one settle period.
          nxt_s_ff.ctl.device_hs_pll_en = tgt[2];
          nxt_s_ff.ctl.host_hs_pll_en = tgt[1];
          nxt_s_ff.cnt = PLL_SETTLE_CYC - 16'h0001;
          nxt_s_ff.moved = 1'b1;
          nxt_s_ff.st = ST_PLL_WAIT;
        end else begin
          if (tgt[2] && tgt[1] && s_ff.ctl.transfer_owner_flag != tgt[0]) begin
            nxt_s_ff.moved = 1'b1;
          end
          if (tgt[2] && tgt[1]) begin
            nxt_s_ff.ctl.transfer_owner_flag = tgt[0];
          end
          nxt_s_ff.req = nxt_s_ff.req & ~s_ff.act;
          if (nxt_s_ff.moved) begin
            nxt_s_ff.done = 1'b1;
          end
          nxt_s_ff.act = 7'h00;
          nxt_s_ff.st = ST_IDLE;
        end
      end
      ST_OSC_WAIT: begin
        // A settle count of zero still costs one cycle before the gate opens.
        if (s_ff.cnt == 16'h0000) begin
          nxt_s_ff.ctl.gated_osc_clock_en = 1'b1;
          nxt_s_ff.st = ST_BUSY;
        end else begin
          nxt_s_ff.cnt = s_ff.cnt - 16'h0001;
        end
      end
      ST_PLL_WAIT: begin
        // Both PLL settle periods share one fixed count, whatever the path.
        if (s_ff.cnt == 16'h0000) begin
          nxt_s_ff.st = ST_BUSY;
        end else begin
          nxt_s_ff.cnt = s_ff.cnt - 16'h0001;
        end
      end
    endcase
    // A completion in the same cycle as a software clear keeps the flag set.
    if (fin && s_ff.moved) begin
      nxt_s_ff.done = 1'b1;
    end
    nxt_s_ff.ctl.device_xfer_en = nxt_s_ff.ctl.device_hs_pll_en
      && !(nxt_s_ff.ctl.host_hs_pll_en && nxt_s_ff.ctl.transfer_owner_flag);
    nxt_s_ff.ctl.host_xfer_en = nxt_s_ff.ctl.host_hs_pll_en
      && !(nxt_s_ff.ctl.device_hs_pll_en && !nxt_s_ff.ctl.transfer_owner_flag);
    // Synchronous sources are unreadable without the base clock, so they cannot raise the line then.
    nxt_s_ff.irq_n = !(async_irq_i || (sync_irq_i && s_ff.ctl.base_pll_en));
  end

  // Reset leaves the bus not ready and every clock source off.
  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      s_ff <= '{st: ST_IDLE, settle: `SETTLE_RESET, irq_n: 1'b1, wait_n: 1'b1, default: '0};
    end else begin
      s_ff <= nxt_s_ff;
    end
  end

  assign avmm_o = '{readdata: {24'h000000, s_ff.rdata}, waitrequest: s_ff.wait_n};
  assign clk_ctrl_o = s_ff.ctl;
  assign interrupt_out_n_o = s_ff.irq_n;

  property p_state_code;
    @(posedge clock_i) disable iff (!rst_b_i)
      state_code inside {4'h0, 4'h1, 4'h3, 4'h7, 4'hB, 4'hF};
  endproperty
  a_state_code: assert property (p_state_code) else $error("illegal state code");

  property p_gate_waits;
    @(posedge clock_i) disable iff (!rst_b_i)
      (s_ff.st == ST_OSC_WAIT && s_ff.cnt != 16'h0000) |=> !s_ff.ctl.gated_osc_clock_en;
  endproperty
  a_gate_waits: assert property (p_gate_waits) else $error("gate opened before count end");

  property p_gate_cause;
    @(posedge clock_i) disable iff (!rst_b_i)
      $rose(s_ff.ctl.gated_osc_clock_en) |-> $past(s_ff.st) == ST_OSC_WAIT && $past(s_ff.cnt) == 16'h0000;
  endproperty
  a_gate_cause: assert property (p_gate_cause) else $error("gate opened without settle");

  property p_pll_timer;
    @(posedge clock_i) disable iff (!rst_b_i)
      $rose(s_ff.ctl.base_pll_en) |-> s_ff.st == ST_PLL_WAIT && s_ff.cnt == PLL_SETTLE_CYC - 16'h0001;
  endproperty
  a_pll_timer: assert property (p_pll_timer) else $error("base pll timer not loaded");

  property p_swap;
    @(posedge clock_i) disable iff (!rst_b_i)
      (fin && s_ff.act[1] && s_ff.ctl.transfer_owner_flag) |=> !s_ff.ctl.transfer_owner_flag && s_ff.done
        && s_ff.ctl.host_hs_pll_en && s_ff.st == ST_IDLE;
  endproperty
  a_swap: assert property (p_swap) else $error("substate swap wrong");

  property p_done;
    @(posedge clock_i) disable iff (!rst_b_i)
      (fin && s_ff.moved) |=> s_ff.done && (s_ff.req & $past(s_ff.act)) == 7'h00;
  endproperty
  a_done: assert property (p_done) else $error("done or request clear missing");

  property p_hold_act;
    @(posedge clock_i) disable iff (!rst_b_i)
      (s_ff.st != ST_IDLE && !fin) |=> $stable(s_ff.act);
  endproperty
  a_hold_act: assert property (p_hold_act) else $error("request changed mid transition");

  property p_irq_mask;
    @(posedge clock_i) disable iff (!rst_b_i)
      (!s_ff.ctl.base_pll_en && !async_irq_i) |=> s_ff.irq_n;
  endproperty
  a_irq_mask: assert property (p_irq_mask) else $error("interrupt not masked in low power");

  property p_xfer;
    @(posedge clock_i) disable iff (!rst_b_i)
      (s_ff.ctl.device_hs_pll_en && s_ff.ctl.host_hs_pll_en) |-> s_ff.ctl.device_xfer_en
        == !s_ff.ctl.transfer_owner_flag && s_ff.ctl.host_xfer_en == s_ff.ctl.transfer_owner_flag;
  endproperty
  a_xfer: assert property (p_xfer) else $error("transfer owner mismatch");

  property p_bus_answer;
    @(posedge clock_i) disable iff (!rst_b_i)
      (access && s_ff.wait_n) |=> !s_ff.wait_n ##1 s_ff.wait_n;
  endproperty
  a_bus_answer: assert property (p_bus_answer) else $error("register access not answered");

  property p_osc_start;
    @(posedge clock_i) disable iff (!rst_b_i)
      $rose(s_ff.ctl.osc_enable) |-> s_ff.st == ST_OSC_WAIT && !s_ff.ctl.gated_osc_clock_en;
  endproperty
  a_osc_start: assert property (p_osc_start) else $error("oscillator started without settle wait");

  property p_hs_start;
    @(posedge clock_i) disable iff (!rst_b_i)
      ($rose(s_ff.ctl.device_hs_pll_en) || $rose(s_ff.ctl.host_hs_pll_en)) |-> s_ff.ctl.base_pll_en
        && s_ff.st == ST_PLL_WAIT && s_ff.cnt == PLL_SETTLE_CYC - 16'h0001;
  endproperty
  a_hs_start: assert property (p_hs_start) else $error("high speed pll started without base or timer");

  property p_host_stop;
    @(posedge clock_i) disable iff (!rst_b_i)
      (s_ff.st == ST_BUSY && s_ff.act[3] && s_ff.ctl.host_hs_pll_en) |=> !s_ff.ctl.host_hs_pll_en
        && s_ff.ctl.base_pll_en;
  endproperty
  a_host_stop: assert property (p_host_stop) else $error("host pll not stopped for device request");

  property p_owner_change;
    @(posedge clock_i) disable iff (!rst_b_i)
      $changed(s_ff.ctl.transfer_owner_flag) |-> $past(fin);
  endproperty
  a_owner_change: assert property (p_owner_change) else $error("owner flag changed outside a completion");

  property p_all_cover;
    @(posedge clock_i) disable iff (!rst_b_i)
      state_code == 4'hF && s_ff.done;
  endproperty
  c_all: cover property (p_all_cover);
  c_wake: cover property (@(posedge clock_i) disable iff (!rst_b_i) $rose(s_ff.ctl.gated_osc_clock_en));
  c_swap: cover property (@(posedge clock_i) disable iff (!rst_b_i) $rose(s_ff.ctl.transfer_owner_flag));
  c_doze: cover property (@(posedge clock_i) disable iff (!rst_b_i) state_code == 4'h1 && s_ff.done);
  c_host: cover property (@(posedge clock_i) disable iff (!rst_b_i) state_code == 4'hB && s_ff.done);
endmodule

// ==== verif/osc_pll_model.sv ====
// Behavioural model of the three PLL macros, referenced to the gated oscillator clock.
`timescale 1ns/1ps
module osc_pll_model
  import pwr_seq_pkg::*;
#(
  parameter int SETTLE = 20
) (
  // Clock and reset.
  input wire logic clock_i,
  input wire logic rst_b_i,
  // Enables from the sequencer.
  input wire pwr_seq_pkg::clk_ctrl_s ctrl_i,
  // Lock of host, device and base PLLs.
  output logic [2:0] locked_o
);
  // A PLL counts only while its reference runs, so starting it early gains nothing.
  int cnt [3];
  logic [2:0] en;
  assign en[0] = ctrl_i.base_pll_en & ctrl_i.gated_osc_clock_en;
  assign en[1] = ctrl_i.device_hs_pll_en & locked_o[0];
  assign en[2] = ctrl_i.host_hs_pll_en & locked_o[0];
  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      cnt <= '{0, 0, 0};
    end else begin
      for (int i = 0; i < 3; i++) begin
        cnt[i] <= en[i] ? ((cnt[i] < SETTLE) ? cnt[i] + 1 : cnt[i]) : 0;
      end
    end
  end
  always_comb begin
    for (int i = 0; i < 3; i++) begin
      locked_o[i] = (cnt[i] >= SETTLE);
    end
  end
endmodule

// ==== verif/power_state_clock_sequencer_bench.sv ====
// Self-checking bench of the power state sequencer.
`timescale 1ns/1ps
`include "pwr_seq_regs.svh"
`define CHK(nm, e, g) begin comparisons++; if ((g) !== (e)) begin num_errors++; \
  $display("ERROR %s expected %h seen %h", nm, e, g); end end
module power_state_clock_sequencer_bench;
  import pwr_seq_pkg::*;
  localparam int SETTLE = 20;
  logic clock_i = 1'b0;
  logic rst_b_i = 1'b0;
  avmm_req_s req = '0;
  avmm_rsp_s rsp;
  logic sync_irq = 1'b0;
  logic async_irq = 1'b0;
  clk_ctrl_s ctrl;
  logic irq_n;
  logic [2:0] locked;
  logic [7:0] rd;
  int num_errors = 0;
  int comparisons = 0;
  int cycles = 0;
  always #5 clock_i = ~clock_i;
  power_state_clock_sequencer #(.PLL_SETTLE_CYC(16'(SETTLE))) power_state_clock_sequencer_inst (
    .clock_i(clock_i), .rst_b_i(rst_b_i), .avmm_i(req), .avmm_o(rsp), .sync_irq_i(sync_irq),
    .async_irq_i(async_irq), .clk_ctrl_o(ctrl), .interrupt_out_n_o(irq_n));
  osc_pll_model #(.SETTLE(SETTLE)) osc_pll_model_inst (
    .clock_i(clock_i), .rst_b_i(rst_b_i), .ctrl_i(ctrl), .locked_o(locked));
  task automatic conclude();
    $display("comparisons %0d mismatches %0d", comparisons, num_errors);
    if (num_errors == 0 && comparisons > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  always @(posedge clock_i) begin
    cycles <= cycles + 1;
    if (cycles == 30000) begin
      num_errors++;
      conclude();
    end
  end
  task automatic acc(input logic wr, input logic [7:0] idx, input logic [7:0] wd, output logic [7:0] q);
    @(posedge clock_i);
    req.address <= {idx[5:0], 2'b00};
    req.read <= !wr;
    req.write <= wr;
    req.writedata <= {24'h000000, wd};
    req.byteenable <= 4'hF;
    do begin
      @(posedge clock_i);
    end while (rsp.waitrequest !== 1'b0);
    q = rsp.readdata[7:0];
    req.read <= 1'b0;
    req.write <= 1'b0;
  endtask
  // Requests a state, waits for completion and checks the settled outputs.
  task automatic go(input logic [7:0] rq, input logic [7:0] mon, input logic [1:0] xf, input int lo, input int hi);
    int t0;
    int n;
    acc(1'b1, `IDX_STATE_REQUEST, rq, rd);
    t0 = cycles;
    n = 0;
    do begin
      acc(1'b0, `IDX_SEQ_STATUS, 8'h00, rd);
      n++;
    end while (rd[0] !== 1'b1 && n < 500);
    `CHK("done flag", 1'b1, rd[0])
    `CHK("switch time", 1'b1, (cycles - t0 >= lo) && (cycles - t0 <= hi))
    repeat (8) @(posedge clock_i);
    acc(1'b0, `IDX_STATE_REQUEST, 8'h00, rd);
    `CHK("request cleared", 8'h00, rd)
    acc(1'b0, `IDX_STATE_MONITOR, 8'h00, rd);
    `CHK("monitor", mon, rd)
    `CHK("enables", {mon[3:0], mon[0]}, {ctrl.host_hs_pll_en, ctrl.device_hs_pll_en, ctrl.base_pll_en,
      ctrl.gated_osc_clock_en, ctrl.osc_enable})
    `CHK("pll lock", mon[3:1], locked)
    `CHK("transfer permits", xf, {ctrl.device_xfer_en, ctrl.host_xfer_en})
    acc(1'b1, `IDX_SEQ_STATUS, 8'h01, rd);
    acc(1'b0, `IDX_SEQ_STATUS, 8'h00, rd);
    `CHK("done cleared", 8'h00, rd)
    $display("test request %h finished", rq);
  endtask
  initial begin
    repeat (16) @(posedge clock_i);
    rst_b_i <= 1'b1;
    acc(1'b0, `IDX_STATE_MONITOR, 8'h00, rd);
    `CHK("monitor reset", 8'h00, rd)
    acc(1'b0, `IDX_SETTLE_HIGH, 8'h00, rd);
    `CHK("settle high reset", 8'h00, rd)
    acc(1'b0, `IDX_SETTLE_LOW, 8'h00, rd);
    `CHK("settle low reset", 8'h00, rd)
    acc(1'b1, 8'h30, 8'hFF, rd);
    acc(1'b0, 8'h30, 8'h00, rd);
    `CHK("unmapped", 8'h00, rd)
    acc(1'b1, `IDX_SETTLE_HIGH, 8'h00, rd);
    acc(1'b1, `IDX_SETTLE_LOW, 8'h05, rd);
    acc(1'b0, `IDX_SETTLE_LOW, 8'h00, rd);
    `CHK("settle low in sleep", 8'h05, rd)
    sync_irq <= 1'b1;
    repeat (3) @(posedge clock_i);
    `CHK("irq masked in sleep", 1'b1, irq_n)
    async_irq <= 1'b1;
    repeat (3) @(posedge clock_i);
    `CHK("async irq", 1'b0, irq_n)
    async_irq <= 1'b0;
    $display("test registers finished");
    go(8'h02, 8'h8F, 2'b01, 45, 200);
    `CHK("irq live", 1'b0, irq_n)
    go(8'h04, 8'h0F, 2'b10, 0, 19);
    acc(1'b1, `IDX_STATE_REQUEST, 8'h04, rd);
    repeat (6) @(posedge clock_i);
    acc(1'b0, `IDX_STATE_REQUEST, 8'h00, rd);
    `CHK("same substate cleared", 8'h00, rd)
    acc(1'b0, `IDX_SEQ_STATUS, 8'h00, rd);
    `CHK("same substate no done", 8'h00, rd)
    go(8'h10, 8'h07, 2'b10, 0, 19);
    go(8'h02, 8'h8F, 2'b01, 20, 100);
    go(8'h40, 8'h81, 2'b00, 0, 19);
    `CHK("irq masked in snooze", 1'b1, irq_n)
    go(8'h04, 8'h0F, 2'b10, 40, 150);
    go(8'h20, 8'h03, 2'b00, 0, 19);
    go(8'h02, 8'h8F, 2'b01, 20, 100);
    sync_irq <= 1'b0;
    go(8'h80, 8'h80, 2'b00, 0, 19);
    acc(1'b1, `IDX_STATE_REQUEST, 8'h02, rd);
    repeat (5) @(posedge clock_i);
    go(8'h06, 8'h0F, 2'b10, 30, 300);
    go(8'h08, 8'h0B, 2'b01, 0, 19);
    go(8'h10, 8'h07, 2'b10, 20, 100);
    sync_irq <= 1'b1;
    repeat (3) @(posedge clock_i);
    `CHK("irq after wake", 1'b0, irq_n)
    conclude();
  end
endmodule
